// ==== pkg/step_pkg.sv ====
// Shared widths, field positions, operation codes and states of the step control
package step_pkg;

    // ==========================================================
    // Word and field layout
    localparam int WORD_W  = 48;
    localparam int INSTR_W = 24;
    localparam int ADDR_W  = 15;
    localparam int BANK_W  = 14;
    localparam int OP_W    = 6;
    localparam int IDX_W   = 3;
    localparam int OP_LSB  = 18;
    localparam int IDX_LSB = 15;
    localparam int SHCNT_W = 6;
    localparam int NUM_IDX = 6;

    // ==========================================================
    // Operation codes and index selector values
    localparam logic [OP_W-1:0]  OP_SHIFT_R   = 6'h01;
    localparam logic [OP_W-1:0]  OP_ADD       = 6'h0c;
    localparam logic [OP_W-1:0]  OP_ENTER_IDX = 6'h28;
    localparam logic [OP_W-1:0]  OP_JUMP      = 6'h22;
    localparam logic [OP_W-1:0]  OP_SKIP_NEG  = 6'h23;
    localparam logic [IDX_W-1:0] IDX_NONE     = 3'h0;
    localparam logic [IDX_W-1:0] IDX_INDIRECT = 3'h7;

    // ==========================================================
    // Reset values and counter steps
    localparam logic [ADDR_W-1:0] P_RESET = 15'h0000;
    localparam logic [ADDR_W-1:0] P_INC   = 15'h0001;
    localparam logic [ADDR_W-1:0] R_DEC   = 15'h7fff;
    localparam logic [ADDR_W-1:0] R_ZERO  = 15'h0000;
    localparam logic [WORD_W-1:0] W_ZERO  = 48'h0000_0000_0000;
    localparam logic [WORD_W-1:0] W_ONES  = 48'hffff_ffff_ffff;

    // ==========================================================
    // Control states
    typedef enum logic [10:0] {
        ST_FETCH  = 11'h001,
        ST_FWAIT  = 11'h002,
        ST_DECODE = 11'h004,
        ST_MODIFY = 11'h008,
        ST_OREQ   = 11'h010,
        ST_OWAIT  = 11'h020,
        ST_EXEC   = 11'h040,
        ST_SHIFT  = 11'h080,
        ST_ENTER  = 11'h100,
        ST_STORE  = 11'h200,
        ST_NEXT   = 11'h400
    } state_t;

endpackage

// ==== pkg/oc_add_if.sv ====
// Operand and result bundle of a closed one's complement adder
`timescale 1ns/10ps
`default_nettype none
interface oc_add_if #(parameter int W = 15);
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic [W-1:0] s;
    modport calc (input a, input b, output s);
    modport user (output a, output b, input s);
endinterface
`default_nettype wire

// ==== hdl/oc_adder.sv ====
// Closed subtractive one's complement adder with end-around borrow
`timescale 1ns/10ps
`default_nettype none
module oc_adder #(
    parameter int W = 15
) (
    oc_add_if.calc port
);

    logic [W:0] diff;

    // a + b done as a - ~b, so only -0 + -0 gives -0
    assign diff   = {1'b0, port.a} - {1'b0, ~port.b};
    // Borrow out of the top stage is taken from the bottom stage
    assign port.s = diff[W] ? (diff[W-1:0] - W'(1)) : diff[W-1:0];

endmodule
`default_nettype wire

// ==== hdl/step_control.sv ====
// Program step fetch, instruction split and index address forming
//
// How it works
// - Top six instruction bits are operation code
// - Next three bits index select, low fifteen base
// - Index select zero uses base address unchanged
// - Index select seven means indirect addressing
// - Step word holds upper then lower instruction
// - Step counter advances; jump loads new address
// - Fetch word at counter into pair holder
// - Upper first; lower unless jump or skip
// - Fetch address bank chosen by counter bit
// - Operand bank chosen by adder low bit
// - Stage index while base enters adder, add
// - Lower half moves up after upper finishes
// - Code 50 enters base into index register
// - Code 14 adds operand into sum register
// - Code 01 shifts sum register right
// - Negatives are bitwise inverted, sign leads
// - Accumulators feed top borrow to bottom
// - Counters open ended, decrement adds all ones
// - Staging register counts down during shifts
// - Six index registers, selects one to six
// - Adder value signed as operand, unsigned address
// - Zero sum is all zeros except minus zero
`timescale 1ns/10ps
`default_nettype none
module step_control (
    input  wire logic                       ref_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       run_en,
    output logic [step_pkg::BANK_W-1:0]     even_addr,
    output logic                            even_req,
    output logic [step_pkg::BANK_W-1:0]     odd_addr,
    output logic                            odd_req,
    input  wire logic                       mem_ack,
    input  wire logic [step_pkg::WORD_W-1:0] mem_rdata,
    output logic [step_pkg::ADDR_W-1:0]     seq_ctr,
    output logic [step_pkg::WORD_W-1:0]     sum_reg,
    output logic [step_pkg::INSTR_W-1:0]    cur_instr,
    output logic                            lower_active,
    output logic                            busy
);

    // ==========================================================
    // Registers and instruction fields
    step_pkg::state_t                  state_ff;
    step_pkg::state_t                  nxt_state;
    logic [step_pkg::WORD_W-1:0]       pair_ff;
    logic [step_pkg::WORD_W-1:0]       sum_ff;
    logic [step_pkg::WORD_W-1:0]       x_ff;
    logic [step_pkg::ADDR_W-1:0]       p_ff;
    logic [step_pkg::ADDR_W-1:0]       u2_ff;
    logic [step_pkg::ADDR_W-1:0]       r_ff;
    logic [step_pkg::ADDR_W-1:0]       b_ff [1:step_pkg::NUM_IDX];
    logic                              lower_ff;
    logic                              skip_ff;
    logic                              ind_ff;
    logic [step_pkg::INSTR_W-1:0]      instr;
    logic [step_pkg::OP_W-1:0]         op;
    logic [step_pkg::IDX_W-1:0]        idx;
    logic [step_pkg::ADDR_W-1:0]       base;
    logic                              idx_valid;
    logic [step_pkg::ADDR_W-1:0]       b_sel;

    // Upper half of the holder is the instruction in force
    assign instr     = pair_ff[step_pkg::WORD_W-1 -: step_pkg::INSTR_W];
    assign op        = instr[step_pkg::OP_LSB +: step_pkg::OP_W];
    assign idx       = instr[step_pkg::IDX_LSB +: step_pkg::IDX_W];
    assign base      = instr[step_pkg::ADDR_W-1:0];
    assign idx_valid = (idx != step_pkg::IDX_NONE) &&
                       (idx != step_pkg::IDX_INDIRECT);
    assign b_sel     = idx_valid ? b_ff[idx] : step_pkg::R_ZERO;

    // ==========================================================
    // Closed adders for address forming and for the sum
    oc_add_if #(.W(step_pkg::ADDR_W)) addr_add ();
    oc_add_if #(.W(step_pkg::WORD_W)) sum_add ();

    assign addr_add.a = u2_ff;
    assign addr_add.b = r_ff;
    assign sum_add.a  = sum_ff;
    assign sum_add.b  = x_ff;

    oc_adder #(.W(step_pkg::ADDR_W)) u_addr_adder (
        .port (addr_add.calc)
    );
    oc_adder #(.W(step_pkg::WORD_W)) u_sum_adder (
        .port (sum_add.calc)
    );

    // ==========================================================
    // Sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            step_pkg::ST_FETCH: begin
                if (run_en) begin
                    nxt_state = step_pkg::ST_FWAIT;
                end
            end
            step_pkg::ST_FWAIT: begin
                if (mem_ack) begin
                    nxt_state = step_pkg::ST_DECODE;
                end
            end
            step_pkg::ST_DECODE: begin
                if (op == step_pkg::OP_JUMP) begin
                    nxt_state = step_pkg::ST_FETCH;
                end else if (op == step_pkg::OP_ENTER_IDX) begin
                    nxt_state = step_pkg::ST_ENTER;
                end else if (op == step_pkg::OP_SHIFT_R) begin
                    nxt_state = step_pkg::ST_SHIFT;
                end else if (op == step_pkg::OP_ADD) begin
                    // No index addition for select zero or seven
                    nxt_state = idx_valid ? step_pkg::ST_MODIFY
                                          : step_pkg::ST_OREQ;
                end else begin
                    nxt_state = step_pkg::ST_NEXT;
                end
            end
            step_pkg::ST_MODIFY: nxt_state = step_pkg::ST_OREQ;
            step_pkg::ST_OREQ:   nxt_state = step_pkg::ST_OWAIT;
            step_pkg::ST_OWAIT: begin
                if (mem_ack) begin
                    nxt_state = ind_ff ? step_pkg::ST_OREQ
                                       : step_pkg::ST_EXEC;
                end
            end
            step_pkg::ST_EXEC:   nxt_state = step_pkg::ST_NEXT;
            step_pkg::ST_SHIFT: begin
                if (r_ff == step_pkg::R_ZERO) begin
                    nxt_state = step_pkg::ST_NEXT;
                end
            end
            step_pkg::ST_ENTER:  nxt_state = step_pkg::ST_STORE;
            step_pkg::ST_STORE:  nxt_state = step_pkg::ST_NEXT;
            step_pkg::ST_NEXT: begin
                nxt_state = (lower_ff || skip_ff) ? step_pkg::ST_FETCH
                                                  : step_pkg::ST_DECODE;
            end
            default:             nxt_state = step_pkg::ST_FETCH;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= step_pkg::ST_FETCH;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // Instruction pair holder, lower half and skip flags
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pair_ff  <= step_pkg::W_ZERO;
            lower_ff <= 1'b0;
            skip_ff  <= 1'b0;
        end else if (state_ff == step_pkg::ST_FWAIT && mem_ack) begin
            pair_ff  <= mem_rdata;
            lower_ff <= 1'b0;
            skip_ff  <= 1'b0;
        end else if (state_ff == step_pkg::ST_DECODE &&
                     op == step_pkg::OP_SKIP_NEG) begin
            // Sign bit set means negative
            skip_ff  <= sum_ff[step_pkg::WORD_W-1];
        end else if (state_ff == step_pkg::ST_NEXT && !lower_ff && !skip_ff) begin
            pair_ff  <= {pair_ff[step_pkg::INSTR_W-1:0],
                         pair_ff[step_pkg::INSTR_W-1:0]};
            lower_ff <= 1'b1;
        end
    end

    // ==========================================================
    // Step counter, open ended
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            p_ff <= step_pkg::P_RESET;
        end else if (state_ff == step_pkg::ST_DECODE &&
                     op == step_pkg::OP_JUMP) begin
            p_ff <= base;
        end else if (state_ff == step_pkg::ST_NEXT && (lower_ff || skip_ff)) begin
            p_ff <= p_ff + step_pkg::P_INC;
        end
    end

    // ==========================================================
    // Address adder contents
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            u2_ff <= step_pkg::R_ZERO;
            ind_ff <= 1'b0;
        end else if (state_ff == step_pkg::ST_DECODE) begin
            u2_ff  <= base;
            ind_ff <= (op == step_pkg::OP_ADD) &&
                      (idx == step_pkg::IDX_INDIRECT);
        end else if (state_ff == step_pkg::ST_MODIFY) begin
            u2_ff <= addr_add.s;
        end else if (state_ff == step_pkg::ST_OWAIT && mem_ack && ind_ff) begin
            // Pointer word gives the final operand address
            u2_ff  <= mem_rdata[step_pkg::ADDR_W-1:0];
            ind_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Index staging register, also a down counter
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_ff <= step_pkg::R_ZERO;
        end else if (state_ff == step_pkg::ST_DECODE) begin
            if (op == step_pkg::OP_SHIFT_R) begin
                r_ff <= step_pkg::ADDR_W'(base[step_pkg::SHCNT_W-1:0]);
            end else begin
                r_ff <= b_sel;
            end
        end else if (state_ff == step_pkg::ST_ENTER) begin
            r_ff <= u2_ff;
        end else if (state_ff == step_pkg::ST_SHIFT &&
                     r_ff != step_pkg::R_ZERO) begin
            r_ff <= r_ff + step_pkg::R_DEC;
        end
    end

    // ==========================================================
    // Six index registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 1; i <= step_pkg::NUM_IDX; i++) begin
                b_ff[i] <= step_pkg::R_ZERO;
            end
        end else if (state_ff == step_pkg::ST_STORE && idx_valid) begin
            b_ff[idx] <= r_ff;
        end
    end

    // ==========================================================
    // Transfer word holder and sum register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            x_ff <= step_pkg::W_ZERO;
        end else if (state_ff == step_pkg::ST_OWAIT && mem_ack && !ind_ff) begin
            x_ff <= mem_rdata;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sum_ff <= step_pkg::W_ZERO;
        end else if (state_ff == step_pkg::ST_EXEC) begin
            sum_ff <= sum_add.s;
        end else if (state_ff == step_pkg::ST_SHIFT &&
                     r_ff != step_pkg::R_ZERO) begin
            // Sign fill keeps one's complement value
            sum_ff <= {sum_ff[step_pkg::WORD_W-1],
                       sum_ff[step_pkg::WORD_W-1:1]};
        end
    end

    // ==========================================================
    // Storage bank address registers and requests
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            even_addr <= '0;
            odd_addr  <= '0;
            even_req  <= 1'b0;
            odd_req   <= 1'b0;
        end else begin
            even_req <= 1'b0;
            odd_req  <= 1'b0;
            if (state_ff == step_pkg::ST_FETCH && run_en) begin
                if (!p_ff[0]) begin
                    even_addr <= p_ff[step_pkg::ADDR_W-1:1];
                    even_req  <= 1'b1;
                end else begin
                    odd_addr  <= p_ff[step_pkg::ADDR_W-1:1];
                    odd_req   <= 1'b1;
                end
            end else if (state_ff == step_pkg::ST_OREQ) begin
                // Adder content taken as unsigned address here
                if (!u2_ff[0]) begin
                    even_addr <= u2_ff[step_pkg::ADDR_W-1:1];
                    even_req  <= 1'b1;
                end else begin
                    odd_addr  <= u2_ff[step_pkg::ADDR_W-1:1];
                    odd_req   <= 1'b1;
                end
            end
        end
    end

    assign seq_ctr      = p_ff;
    assign sum_reg      = sum_ff;
    assign cur_instr    = instr;
    assign lower_active = lower_ff;
    assign busy         = (state_ff != step_pkg::ST_FETCH);

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_fetch_even: assert property (
        state_ff == step_pkg::ST_FETCH && run_en && !p_ff[0]
        |=> even_req && !odd_req && even_addr == $past(p_ff[14:1]))
        else $error("even fetch misrouted");
    chk_fetch_odd: assert property (
        state_ff == step_pkg::ST_FETCH && run_en && p_ff[0]
        |=> odd_req && !even_req && odd_addr == $past(p_ff[14:1]))
        else $error("odd fetch misrouted");
    chk_oper_bank: assert property (
        state_ff == step_pkg::ST_OREQ
        |=> (even_req == !$past(u2_ff[0])) && (odd_req == $past(u2_ff[0])))
        else $error("operand bank wrong");
    chk_no_index: assert property (
        state_ff == step_pkg::ST_DECODE && op == step_pkg::OP_ADD &&
        idx == step_pkg::IDX_NONE
        |=> state_ff == step_pkg::ST_OREQ ##1 even_req != odd_req &&
            (even_req ? even_addr : odd_addr) == $past(base[14:1], 2))
        else $error("unindexed address altered");
    chk_indirect_path: assert property (
        state_ff == step_pkg::ST_DECODE && op == step_pkg::OP_ADD &&
        idx == step_pkg::IDX_INDIRECT
        |=> ind_ff && state_ff == step_pkg::ST_OREQ)
        else $error("indirect not taken");
    chk_modify_path: assert property (
        state_ff == step_pkg::ST_DECODE && op == step_pkg::OP_ADD && idx_valid
        |=> r_ff == $past(b_sel) && u2_ff == $past(base)
            ##1 state_ff == step_pkg::ST_OREQ)
        else $error("index staging wrong");
    chk_step_adv: assert property (
        state_ff == step_pkg::ST_NEXT && (lower_ff || skip_ff)
        |=> p_ff == $past(p_ff) + step_pkg::P_INC &&
            state_ff == step_pkg::ST_FETCH)
        else $error("step counter not advanced");
    chk_jump_load: assert property (
        state_ff == step_pkg::ST_DECODE && op == step_pkg::OP_JUMP
        |=> p_ff == $past(base) && state_ff == step_pkg::ST_FETCH)
        else $error("jump not taken");
    chk_lower_move: assert property (
        state_ff == step_pkg::ST_NEXT && !lower_ff && !skip_ff
        |=> lower_ff && instr == $past(pair_ff[23:0]) &&
            state_ff == step_pkg::ST_DECODE)
        else $error("lower instruction not moved");
    chk_enter_index: assert property (
        state_ff == step_pkg::ST_DECODE && op == step_pkg::OP_ENTER_IDX &&
        idx_valid
        |-> ##3 b_ff[$past(idx, 3)] == $past(base, 3))
        else $error("index entry lost");
    chk_neg_zero: assert property (
        state_ff == step_pkg::ST_EXEC && sum_ff == step_pkg::W_ONES &&
        x_ff == step_pkg::W_ONES
        |=> sum_ff == step_pkg::W_ONES)
        else $error("negative zero lost");
    chk_pos_zero: assert property (
        state_ff == step_pkg::ST_EXEC && x_ff == ~sum_ff &&
        sum_ff != step_pkg::W_ONES && sum_ff != step_pkg::W_ZERO
        |=> sum_ff == step_pkg::W_ZERO)
        else $error("end-around borrow wrong");
    chk_shift_count: assert property (
        state_ff == step_pkg::ST_SHIFT && r_ff != step_pkg::R_ZERO
        |=> r_ff == $past(r_ff) - step_pkg::P_INC &&
            sum_ff[46:0] == $past(sum_ff[47:1]))
        else $error("shift count wrong");

    cov_jump:  cover property (state_ff == step_pkg::ST_DECODE &&
                               op == step_pkg::OP_JUMP);
    cov_ind:   cover property (state_ff == step_pkg::ST_OWAIT && ind_ff &&
                               mem_ack);
    cov_enter: cover property (state_ff == step_pkg::ST_STORE && idx_valid);
    cov_pair:  cover property (state_ff == step_pkg::ST_NEXT && lower_ff);

endmodule
`default_nettype wire

// ==== test/store_model.sv ====
// Behavioural even and odd core storage answering step control reads
`timescale 1ns/10ps
`default_nettype none
module store_model (
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        even_req,
    input  wire logic [step_pkg::BANK_W-1:0] even_addr,
    input  wire logic                        odd_req,
    input  wire logic [step_pkg::BANK_W-1:0] odd_addr,
    input  wire logic [3:0]                  dly,
    output var  logic                        mem_ack,
    output var  logic [step_pkg::WORD_W-1:0] mem_rdata
);
    logic [step_pkg::WORD_W-1:0] mem [0:63];
    logic [5:0]                  idx_ff;
    logic [3:0]                  cnt_ff;
    logic                        pend_ff;

    // ==========================================================
    // Read service; data lines toggle whenever no word is valid
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_ff   <= 1'b0;
            cnt_ff    <= 4'h0;
            idx_ff    <= 6'h00;
            mem_ack   <= 1'b0;
            mem_rdata <= 48'h5555_5555_5555;
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (even_req) begin
                pend_ff <= 1'b1;
                cnt_ff  <= dly;
                idx_ff  <= {even_addr[4:0], 1'b0};
            end else if (odd_req) begin
                pend_ff <= 1'b1;
                cnt_ff  <= dly;
                idx_ff  <= {odd_addr[4:0], 1'b1};
            end else if (pend_ff && cnt_ff == 4'h0) begin
                pend_ff   <= 1'b0;
                mem_ack   <= 1'b1;
                mem_rdata <= mem[idx_ff];
            end else if (pend_ff) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench running a short program through the step control
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                        ref_clk;
    logic                        sys_rst;
    logic                        run_en;
    logic [3:0]                  dly;
    logic [step_pkg::BANK_W-1:0] even_addr;
    logic [step_pkg::BANK_W-1:0] odd_addr;
    logic                        even_req;
    logic                        odd_req;
    logic                        mem_ack;
    logic [step_pkg::WORD_W-1:0] mem_rdata;
    logic [step_pkg::ADDR_W-1:0] seq_ctr;
    logic [step_pkg::WORD_W-1:0] sum_reg;
    logic [step_pkg::INSTR_W-1:0] cur_instr;
    logic                        lower_active;
    logic                        busy;
    int                          error_cnt;
    int                          compares;
    int                          cyc;

    step_control u_step_control (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .run_en(run_en), .even_addr(even_addr), .even_req(even_req),
        .odd_addr(odd_addr), .odd_req(odd_req), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .seq_ctr(seq_ctr), .sum_reg(sum_reg),
        .cur_instr(cur_instr), .lower_active(lower_active), .busy(busy));
    store_model u_store_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .even_req(even_req), .even_addr(even_addr), .odd_req(odd_req),
        .odd_addr(odd_addr), .dly(dly), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    function automatic logic [23:0] ins(logic [5:0] op, logic [2:0] sel,
                                        logic [14:0] base);
        return {op, sel, base};
    endfunction

    task automatic complete_run();
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp_word(string what, logic [47:0] exp, logic [47:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_ctr(string what, logic [14:0] exp, logic [14:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits for the step counter to reach a value, then checks the sum
    task automatic step_done(logic [14:0] nxt, logic [47:0] sum);
        for (int i = 0; i < 400 && seq_ctr !== nxt; i++) begin
            @(posedge ref_clk);
            #1;
        end
        cmp_ctr("seq_ctr", nxt, seq_ctr);
        cmp_word("sum_reg", sum, sum_reg);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ==========================================================
    // Program and data, then the main sequence
    initial begin
        sys_rst = 1'b1;
        run_en  = 1'b0;
        dly     = 4'h0;
        for (int i = 0; i < 64; i++) u_store_model.mem[i] = 48'h0000_0000_0000;
        u_store_model.mem[0]  = {ins(step_pkg::OP_ENTER_IDX, 3'h1, 15'h0005),
                                 ins(step_pkg::OP_ENTER_IDX, 3'h2, 15'h7ffe)};
        u_store_model.mem[1]  = {ins(step_pkg::OP_ADD, 3'h1, 15'h0010),
                                 ins(step_pkg::OP_ADD, 3'h2, 15'h0010)};
        u_store_model.mem[2]  = {ins(step_pkg::OP_ADD, 3'h0, 15'h0020),
                                 ins(step_pkg::OP_SHIFT_R, 3'h0, 15'h0001)};
        u_store_model.mem[3]  = {ins(step_pkg::OP_JUMP, 3'h0, 15'h0008),
                                 ins(step_pkg::OP_ADD, 3'h0, 15'h0015)};
        u_store_model.mem[8]  = {ins(step_pkg::OP_ADD, 3'h7, 15'h0021), 24'h0};
        u_store_model.mem[9]  = {ins(step_pkg::OP_SKIP_NEG, 3'h0, 15'h0000),
                                 ins(step_pkg::OP_ADD, 3'h0, 15'h0015)};
        u_store_model.mem[10] = {ins(step_pkg::OP_ADD, 3'h0, 15'h0015), 24'h0};
        u_store_model.mem[11] = {ins(step_pkg::OP_SKIP_NEG, 3'h0, 15'h0000),
                                 ins(step_pkg::OP_ADD, 3'h0, 15'h0023)};
        u_store_model.mem[12] = {ins(step_pkg::OP_ADD, 3'h0, 15'h0024),
                                 ins(step_pkg::OP_SHIFT_R, 3'h0, 15'h0001)};
        u_store_model.mem[13] = {ins(step_pkg::OP_ADD, 3'h0, 15'h0025),
                                 ins(step_pkg::OP_SHIFT_R, 3'h0, 15'h0000)};
        u_store_model.mem[15] = 48'h0000_0000_0003;
        u_store_model.mem[21] = 48'h0000_0000_0005;
        u_store_model.mem[32] = 48'hffff_ffff_fffd;
        u_store_model.mem[33] = 48'h0000_0000_0022;
        u_store_model.mem[34] = 48'hffff_ffff_fffa;
        u_store_model.mem[35] = 48'hffff_ffff_fffc;
        u_store_model.mem[36] = 48'hffff_ffff_fffe;
        u_store_model.mem[37] = 48'hffff_ffff_ffff;
        repeat (20) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        cmp_word("busy", 48'h0, {47'h0, busy});
        cmp_word("sum_reg", 48'h0, sum_reg);
        run_en = 1'b1;
        for (int i = 0; i < 400 && lower_active !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        cmp_word("cur_instr", {24'h0, u_store_model.mem[0][23:0]},
                 {24'h0, cur_instr});
        step_done(15'h0001, 48'h0);
        step_done(15'h0002, 48'h0000_0000_0008);
        dly = 4'h3;
        step_done(15'h0003, 48'h0000_0000_0003);
        step_done(15'h0008, 48'h0000_0000_0003);
        step_done(15'h0009, 48'hffff_ffff_fffd);
        step_done(15'h000a, 48'hffff_ffff_fffd);
        step_done(15'h000b, 48'h0000_0000_0003);
        step_done(15'h000c, 48'h0000_0000_0000);
        step_done(15'h000d, 48'hffff_ffff_ffff);
        step_done(15'h000e, 48'hffff_ffff_ffff);
        run_en = 1'b0;
        repeat (30) @(posedge ref_clk);
        #1;
        cmp_ctr("seq_ctr", 15'h000e, seq_ctr);
        cmp_word("busy", 48'h0, {47'h0, busy});
        complete_run();
    end
endmodule
`default_nettype wire
